// *** common/ihrp_pkg.sv ***
package ihrp_pkg;
    // Build-time choice of the single host access interface
    typedef enum {IF_LOCAL, IF_APB, IF_AHB} ihrp_host_if_t;

    // Local port transaction phases
    typedef enum {PS_IDLE, PS_READ, PS_WRITE} ihrp_port_st_t;

    // Bus bridge phases
    typedef enum {BR_IDLE, BR_ISSUE, BR_WAIT} ihrp_br_st_t;

    // Bus address bits that carry the register offset
    localparam int            OFF_LSB      = 2;
    localparam int            OFF_MSB      = 9;

    // Register offsets kept inside the port
    localparam logic [7:0]    IRQ_EN_OFF   = 8'hF0;
    localparam logic [7:0]    IRQ_STAT_OFF = 8'hF1;
    localparam logic [7:0]    ODR_OFF      = 8'hF2;

    // Values after reset
    localparam logic [7:0]    IRQ_EN_RST   = 8'h00;
    localparam logic [7:0]    ODR_RST      = 8'h32;
    localparam logic [7:0]    MEM_RST      = 8'h00;
    localparam logic [31:0]   BUS_RD_RST   = 32'h0000_0000;

    // Register offset from a 32-bit bus address
    function automatic logic [7:0] bus_offset(input logic [31:0] addr);
        bus_offset = addr[OFF_MSB:OFF_LSB];
    endfunction : bus_offset
endpackage : ihrp_pkg

// *** common/ihrp_lcl_if.sv ***
// Local register port as seen between the bus bridge and the port logic
interface ihrp_lcl_if;
    logic       req;          // Transaction request
    logic       wr;           // High write, low read
    logic [7:0] offset;       // Register offset
    logic [7:0] wdata;        // Write byte
    logic [7:0] rdata;        // Read byte
    logic       rdata_valid;  // Read finished, rdata good
    logic       ready;        // Port can take a new request

    modport requester (output req, wr, offset, wdata, input rdata, rdata_valid, ready);
    modport responder (input req, wr, offset, wdata, output rdata, rdata_valid, ready);
endinterface : ihrp_lcl_if

// *** rtl/ihrp_reg_mem.sv ***
// Byte-wide register store with registered read data
module ihrp_reg_mem
    import ihrp_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       clr,
    input  wire logic       we,
    input  wire logic       re,
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wdata,
    output logic      [7:0] rdata_q
);
    // Storage; flops so a port reset can restore every byte
    logic [7:0] mem_q [256];

    ////////////////////////////////////////////////////////////////////////////
    // Write and clear; clear costs area but restores defaults in one cycle
    always_ff @(posedge sys_clk) begin
        if (clr) begin
            for (int i = 0; i < 256; i++) begin
                mem_q[i] <= MEM_RST;
            end
        end else if (we) begin
            mem_q[addr] <= wdata;
        end
    end

    // Read register, held between reads
    always_ff @(posedge sys_clk) begin
        if (clr) begin
            rdata_q <= MEM_RST;
        end else if (re) begin
            rdata_q <= mem_q[addr];
        end
    end
endmodule : ihrp_reg_mem

// *** rtl/ihrp_bus_bridge.sv ***
// AHB-Lite or APB slave turned into local port transactions
module ihrp_bus_bridge
    import ihrp_pkg::*;
#(
    parameter ihrp_host_if_t HOST_IF = IF_LOCAL
) (
    input  wire logic        sys_clk,
    input  wire logic        rst,
    ihrp_lcl_if.requester    lcl,
    input  wire logic        hsel,
    input  wire logic        hready,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [31:0] hwdata,
    output logic             hreadyout_q,
    output logic [31:0]      rdat_q,
    output logic             hresp_q,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic [31:0] paddr,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic             pready_q,
    output logic             pslverr_q
);
    localparam bit IS_AHB = (HOST_IF == IF_AHB);
    localparam bit IS_APB = (HOST_IF == IF_APB);

    ihrp_br_st_t st_q, st_d;             // Bridge phase
    logic        req_q, req_d;           // Request to local port
    logic        wr_q, wr_d;             // Direction held for transfer
    logic [7:0]  off_q, off_d;           // Decoded offset
    logic [7:0]  wdat_q, wdat_d;         // Low write byte
    logic        hrdy_d, prdy_d;         // Bus ready next values
    logic [31:0] rdat_d;                 // Read word next value
    logic        ahb_addr_ok;            // Valid AHB address phase

    assign ahb_addr_ok = hsel && hready && htrans[1];
    assign lcl.req     = req_q;
    assign lcl.wr      = wr_q;
    assign lcl.offset  = off_q;
    assign lcl.wdata   = wdat_q;

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic of the bridge
    always_comb begin
        st_d   = st_q;
        req_d  = 1'b0;
        wr_d   = wr_q;
        off_d  = off_q;
        wdat_d = wdat_q;
        hrdy_d = hreadyout_q;
        prdy_d = 1'b0;
        rdat_d = rdat_q;
        case (st_q)
            BR_IDLE: begin
                if (IS_AHB && ahb_addr_ok) begin
                    wr_d   = hwrite;
                    off_d  = bus_offset(haddr);
                    hrdy_d = 1'b0;
                    st_d   = BR_ISSUE;
                end else if (IS_APB && psel && penable && !pready_q) begin
                    wr_d   = pwrite;
                    off_d  = bus_offset(paddr);
                    wdat_d = pwdata[7:0];
                    req_d  = 1'b1;
                    st_d   = BR_WAIT;
                end
            end
            BR_ISSUE: begin
                wdat_d = hwdata[7:0];
                req_d  = 1'b1;
                st_d   = BR_WAIT;
            end
            default: begin
                if (lcl.ready && !req_q) begin
                    st_d   = BR_IDLE;
                    hrdy_d = 1'b1;
                    prdy_d = IS_APB;
                    if (lcl.rdata_valid) begin
                        rdat_d = {24'h00_0000, lcl.rdata};
                    end
                end
            end
        endcase
    end

    // Registers of the bridge; ready resets high so an idle AHB bus runs
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st_q        <= BR_IDLE;
            req_q       <= 1'b0;
            wr_q        <= 1'b0;
            off_q       <= 8'h00;
            wdat_q      <= 8'h00;
            hreadyout_q <= 1'b1;
            pready_q    <= 1'b0;
            rdat_q      <= BUS_RD_RST;
            hresp_q     <= 1'b0;
            pslverr_q   <= 1'b0;
        end else begin
            st_q        <= st_d;
            req_q       <= req_d;
            wr_q        <= wr_d;
            off_q       <= off_d;
            wdat_q      <= wdat_d;
            hreadyout_q <= hrdy_d;
            pready_q    <= prdy_d;
            rdat_q      <= rdat_d;
            hresp_q     <= 1'b0;
            pslverr_q   <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    a_bridge_single_req: assert property (req_q |=> !req_q)
        else $error("bridge request longer than one cycle");
    a_apb_offset_take: assert property (
        (IS_APB && st_q == BR_IDLE && psel && penable && !pready_q)
        |=> req_q && off_q == $past(paddr[9:2]))
        else $error("apb offset not taken from address bits");
    a_bus_okay_resp: assert property ((hreadyout_q || pready_q) |-> !hresp_q && !pslverr_q)
        else $error("bus error response raised");
    c_ahb_transfer: cover property (IS_AHB && ahb_addr_ok ##[1:8] hreadyout_q);
endmodule : ihrp_bus_bridge

// *** rtl/ihrp_top.sv ***
module ihrp_top
    import ihrp_pkg::*;
#(
    parameter ihrp_host_if_t HOST_IF = IF_LOCAL
) (
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        lcl_rst_n,
    input  wire logic        lcl_req,
    input  wire logic        lcl_wr_rd_n,
    input  wire logic [7:0]  lcl_offset,
    input  wire logic [7:0]  lcl_wdata,
    output logic      [7:0]  lcl_rdata,
    output logic             lcl_rdata_valid,
    output logic             lcl_ready,
    input  wire logic [7:0]  irq_src,
    output logic             host_irq,
    input  wire logic        xtime_odr_valid,
    input  wire logic [7:0]  xtime_odr,
    output logic      [7:0]  sensor_odr,
    input  wire logic        ahb_hsel,
    input  wire logic        ahb_hready,
    input  wire logic [31:0] ahb_haddr,
    input  wire logic [2:0]  ahb_hburst,
    input  wire logic [2:0]  ahb_hsize,
    input  wire logic        ahb_hmastlock,
    input  wire logic [3:0]  ahb_hprot,
    input  wire logic [1:0]  ahb_htrans,
    input  wire logic        ahb_hwrite,
    input  wire logic [31:0] ahb_hwdata,
    output logic             ahb_hreadyout,
    output logic      [31:0] ahb_hrdata,
    output logic             ahb_hresp,
    input  wire logic [31:0] apb_paddr,
    input  wire logic        apb_psel,
    input  wire logic        apb_penable,
    input  wire logic        apb_pwrite,
    input  wire logic [31:0] apb_pwdata,
    output logic             apb_pready,
    output logic      [31:0] apb_prdata,
    output logic             apb_pslverr
);
    ////////////////////////////////////////////////////////////////////////////
    // Declarations
    localparam bit USE_LOCAL = (HOST_IF == IF_LOCAL);

    ihrp_lcl_if    port_if ();            // Bridge to port logic
    logic          port_rst;              // Host side reset
    logic          m_req;                 // Selected request
    logic          m_wr;                  // Selected direction
    logic [7:0]    m_off;                 // Selected offset
    logic [7:0]    m_wdata;               // Selected write byte
    logic          accept;                // Request taken this edge
    logic          acc_rd;                // Read taken this edge
    logic [7:0]    mem_rdata;             // Store read byte
    logic [31:0]   bus_rdat;              // Shared bus read word

    ihrp_port_st_t st_q, st_d;            // Port phase
    logic          ready_q, ready_d;      // Port ready
    logic          valid_q, valid_d;      // Read data valid
    logic [7:0]    rdata_q, rdata_d;      // Read byte out
    logic [7:0]    off_q, off_d;          // Offset of read in flight
    logic [7:0]    irq_en_q, irq_en_d;    // Interrupt enables
    logic          irq_q, irq_d;          // Interrupt line
    logic [7:0]    odr_q, odr_d;          // Sensor data rate

    // port reset also clears host side
    assign port_rst = rst || !lcl_rst_n;

    // only the chosen interface feeds the port
    assign m_req   = USE_LOCAL ? lcl_req     : port_if.req;
    assign m_wr    = USE_LOCAL ? lcl_wr_rd_n : port_if.wr;
    assign m_off   = USE_LOCAL ? lcl_offset  : port_if.offset;
    assign m_wdata = USE_LOCAL ? lcl_wdata   : port_if.wdata;

    // a request counts only while ready
    assign accept  = m_req && ready_q;
    assign acc_rd  = accept && !m_wr;

    // Port answers back to the bridge
    assign port_if.ready       = ready_q;
    assign port_if.rdata_valid = valid_q;
    assign port_if.rdata       = rdata_q;

    ////////////////////////////////////////////////////////////////////////////
    // Register store; read data land one edge after acceptance
    ihrp_reg_mem u_mem (
        .sys_clk (sys_clk),
        .clr     (port_rst),
        .we      (accept && m_wr),
        .re      (acc_rd),
        .addr    (m_off),
        .wdata   (m_wdata),
        .rdata_q (mem_rdata)
    );

    // Bus slave; idle and untouched unless the build selects a bus
    ihrp_bus_bridge #(
        .HOST_IF (HOST_IF)
    ) u_bridge (
        .sys_clk     (sys_clk),
        .rst         (port_rst),
        .lcl         (port_if.requester),
        .hsel        (ahb_hsel),
        .hready      (ahb_hready),
        .haddr       (ahb_haddr),
        .htrans      (ahb_htrans),
        .hwrite      (ahb_hwrite),
        .hwdata      (ahb_hwdata),
        .hreadyout_q (ahb_hreadyout),
        .rdat_q      (bus_rdat),
        .hresp_q     (ahb_hresp),
        .psel        (apb_psel),
        .penable     (apb_penable),
        .paddr       (apb_paddr),
        .pwrite      (apb_pwrite),
        .pwdata      (apb_pwdata),
        .pready_q    (apb_pready),
        .pslverr_q   (apb_pslverr)
    );

    // Both bus read words come from one register in the bridge
    assign ahb_hrdata = bus_rdat;
    assign apb_prdata = bus_rdat;

    ////////////////////////////////////////////////////////////////////////////
    // Port sequencing: one busy cycle per transaction
    always_comb begin
        st_d     = st_q;
        ready_d  = ready_q;
        valid_d  = 1'b0;
        rdata_d  = rdata_q;
        off_d    = off_q;
        irq_en_d = irq_en_q;
        case (st_q)
            PS_IDLE: begin
                ready_d = 1'b1;
                if (accept) begin
                    ready_d = 1'b0;
                    off_d   = m_off;
                    st_d    = m_wr ? PS_WRITE : PS_READ;
                    if (m_wr && m_off == IRQ_EN_OFF) begin
                        irq_en_d = m_wdata;
                    end
                end
            end
            PS_READ: begin
                // valid only with the finished byte
                valid_d = 1'b1;
                ready_d = 1'b1;
                st_d    = PS_IDLE;
                if (off_q == IRQ_EN_OFF) begin
                    rdata_d = irq_en_q;
                end else if (off_q == IRQ_STAT_OFF) begin
                    rdata_d = irq_src;
                end else if (off_q == ODR_OFF) begin
                    rdata_d = odr_q;
                end else begin
                    rdata_d = mem_rdata;
                end
            end
            default: begin
                // Write already stored, ready returns
                ready_d = 1'b1;
                st_d    = PS_IDLE;
            end
        endcase
    end

    // port registers and enables return to defaults
    always_ff @(posedge sys_clk) begin
        if (port_rst) begin
            st_q     <= PS_IDLE;
            ready_q  <= 1'b0;
            valid_q  <= 1'b0;
            rdata_q  <= MEM_RST;
            off_q    <= 8'h00;
            irq_en_q <= IRQ_EN_RST;
        end else begin
            st_q     <= st_d;
            ready_q  <= ready_d;
            valid_q  <= valid_d;
            rdata_q  <= rdata_d;
            off_q    <= off_d;
            irq_en_q <= irq_en_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt and sensor rate
    always_comb begin
        // level while any enabled source is up
        irq_d = |(irq_src & irq_en_q);
        odr_d = xtime_odr_valid ? xtime_odr : odr_q;
    end

    // Rate follows the serial engine, so only system reset loads ODR_RST into it
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            odr_q <= ODR_RST;
        end else begin
            odr_q <= odr_d;
        end
    end

    // Interrupt line, one register delay behind its sources
    always_ff @(posedge sys_clk) begin
        if (port_rst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= irq_d;
        end
    end

    assign lcl_rdata       = rdata_q;
    assign lcl_rdata_valid = valid_q;
    assign lcl_ready       = ready_q;
    assign host_irq        = irq_q;
    assign sensor_odr      = odr_q;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (port_rst);

    a_read_valid_time: assert property (acc_rd |=> !lcl_rdata_valid ##1 lcl_rdata_valid)
        else $error("read valid not two edges after read request");
    a_valid_only_read: assert property (lcl_rdata_valid |-> $past(acc_rd, 2))
        else $error("read valid without a read request");
    a_ready_busy_gap: assert property (accept |=> !lcl_ready ##1 lcl_ready)
        else $error("ready not low exactly one cycle after request");
    a_irq_enabled_level: assert property (
        ##1 host_irq == $past(|(irq_src & irq_en_q)))
        else $error("interrupt line does not follow enabled sources");
    a_irq_en_write: assert property (
        (accept && m_wr && m_off == IRQ_EN_OFF) |=> irq_en_q == $past(m_wdata))
        else $error("enable register not written");
    a_port_reset_clear: assert property (
        @(posedge sys_clk) disable iff (rst)
        !lcl_rst_n |=> irq_en_q == IRQ_EN_RST && !lcl_ready && !host_irq)
        else $error("port reset did not restore defaults");
    a_odr_capture_new: assert property (
        @(posedge sys_clk) disable iff (rst)
        xtime_odr_valid |=> sensor_odr == $past(xtime_odr))
        else $error("sensor rate not updated");
    a_odr_hold_value: assert property (
        @(posedge sys_clk) disable iff (rst)
        !xtime_odr_valid |=> $stable(sensor_odr))
        else $error("sensor rate changed without a command");

    c_local_read: cover property (acc_rd ##2 lcl_rdata_valid);
    c_local_write: cover property (accept && m_wr ##1 !lcl_ready ##1 lcl_ready);
    c_irq_raised: cover property (!host_irq ##1 host_irq);
endmodule : ihrp_top

// *** sim/ihrp_host_model.sv ***
// Host requester for the local, APB and AHB-Lite ports
module ihrp_host_model (
    input  logic        sys_clk,
    input  logic        lcl_ready,
    input  logic        lcl_rdata_valid,
    input  logic [7:0]  lcl_rdata,
    input  logic        ahb_hreadyout,
    input  logic [31:0] ahb_hrdata,
    input  logic        apb_pready,
    input  logic [31:0] apb_prdata,
    output logic        lcl_req,
    output logic        lcl_wr_rd_n,
    output logic [7:0]  lcl_offset,
    output logic [7:0]  lcl_wdata,
    output logic        ahb_hsel,
    output logic [31:0] ahb_haddr,
    output logic [1:0]  ahb_htrans,
    output logic        ahb_hwrite,
    output logic [31:0] ahb_hwdata,
    output logic [31:0] apb_paddr,
    output logic        apb_psel,
    output logic        apb_penable,
    output logic        apb_pwrite,
    output logic [31:0] apb_pwdata
);
    timeunit 1ns;
    timeprecision 1ps;

    // All requests idle at time zero
    initial begin
        {lcl_req, lcl_wr_rd_n, lcl_offset, lcl_wdata} = 0;
        {ahb_hsel, ahb_haddr, ahb_htrans, ahb_hwrite, ahb_hwdata} = 0;
        {apb_paddr, apb_psel, apb_penable, apb_pwrite, apb_pwdata} = 0;
    end

    ////////////////////////////////////////////////////////////////
    // One local transfer; released lines flip so stale data looks wrong
    task automatic lcl_xfer(input logic w, input logic [7:0] off, input logic [7:0] wd, output logic [7:0] rd);
        for (int n = 0; n < 20 && lcl_ready !== 1'b1; n++) @(posedge sys_clk);
        lcl_req     <= 1'b1;
        lcl_wr_rd_n <= w;
        lcl_offset  <= off;
        lcl_wdata   <= wd;
        @(posedge sys_clk);
        lcl_req    <= 1'b0;
        lcl_offset <= ~off;
        lcl_wdata  <= ~wd;
        for (int n = 0; n < 8 && !w && lcl_rdata_valid !== 1'b1; n++) @(posedge sys_clk);
        rd = w ? 8'h00 : lcl_rdata;
        @(posedge sys_clk);
    endtask : lcl_xfer

    ////////////////////////////////////////////////////////////////
    // Setup then access, held to the ready edge
    task automatic apb_xfer(input logic w, input logic [31:0] addr, input logic [31:0] wd, output logic [31:0] rd);
        apb_psel    <= 1'b1;
        apb_penable <= 1'b0;
        apb_pwrite  <= w;
        apb_paddr   <= addr;
        apb_pwdata  <= wd;
        @(posedge sys_clk);
        apb_penable <= 1'b1;
        @(posedge sys_clk);
        for (int n = 0; n < 20 && apb_pready !== 1'b1; n++) @(posedge sys_clk);
        rd = apb_prdata;
        apb_psel    <= 1'b0;
        apb_penable <= 1'b0;
        apb_paddr   <= ~addr;
        apb_pwdata  <= ~wd;
        @(posedge sys_clk);
    endtask : apb_xfer

    ////////////////////////////////////////////////////////////////
    // Single NONSEQ transfer, data held while stretched
    task automatic ahb_xfer(input logic w, input logic [31:0] addr, input logic [31:0] wd, output logic [31:0] rd);
        for (int n = 0; n < 20 && ahb_hreadyout !== 1'b1; n++) @(posedge sys_clk);
        ahb_hsel   <= 1'b1;
        ahb_htrans <= 2'h2;
        ahb_haddr  <= addr;
        ahb_hwrite <= w;
        @(posedge sys_clk);
        ahb_hsel   <= 1'b0;
        ahb_htrans <= 2'h0;
        ahb_haddr  <= ~addr;
        ahb_hwdata <= wd;
        @(posedge sys_clk);
        for (int n = 0; n < 20 && ahb_hreadyout !== 1'b1; n++) @(posedge sys_clk);
        rd = ahb_hrdata;
        ahb_hwdata <= ~wd;
        @(posedge sys_clk);
    endtask : ahb_xfer
endmodule : ihrp_host_model

// *** sim/ihrp_top_bench.sv ***
// Three builds side by side: 0 local port, 1 APB, 2 AHB-Lite
module ihrp_top_bench
    import ihrp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk;
    logic        rst;
    logic        lcl_rst_n;
    logic [7:0]  irq_src;
    logic        xtime_odr_valid;
    logic [7:0]  xtime_odr;
    wire         lcl_req, lcl_wr_rd_n, ahb_hsel, ahb_hwrite, apb_psel, apb_penable, apb_pwrite;
    wire  [7:0]  lcl_offset, lcl_wdata;
    wire  [1:0]  ahb_htrans;
    wire  [31:0] ahb_haddr, ahb_hwdata, apb_paddr, apb_pwdata;
    wire  [7:0]  lcl_rdata [3], sensor_odr [3];
    wire         lcl_rdata_valid [3], lcl_ready [3], host_irq [3], ahb_hreadyout [3], ahb_hresp [3];
    wire         apb_pready [3], apb_pslverr [3];
    wire  [31:0] ahb_hrdata [3], apb_prdata [3];
    int          err_count = 0;
    int          num_checks = 0;
    int          cycles = 0;
    logic        stray = 1'b0;    // An unbuilt option moved
    localparam ihrp_host_if_t BUILD [3] = '{IF_LOCAL, IF_APB, IF_AHB};

    ////////////////////////////////////////////////////////////////
    for (genvar g = 0; g < 3; g++) begin : g_build
        ihrp_top #(.HOST_IF(BUILD[g])) u_ihrp_top (
            .sys_clk, .rst, .lcl_rst_n, .lcl_req, .lcl_wr_rd_n, .lcl_offset, .lcl_wdata, .lcl_rdata(lcl_rdata[g]),
            .lcl_rdata_valid(lcl_rdata_valid[g]), .lcl_ready(lcl_ready[g]), .irq_src, .host_irq(host_irq[g]),
            .xtime_odr_valid, .xtime_odr, .sensor_odr(sensor_odr[g]), .ahb_hsel, .ahb_hready(ahb_hreadyout[2]),
            .ahb_haddr, .ahb_hburst(3'h0), .ahb_hsize(3'h0), .ahb_hmastlock(1'b0), .ahb_hprot(4'h3), .ahb_htrans,
            .ahb_hwrite, .ahb_hwdata, .ahb_hreadyout(ahb_hreadyout[g]), .ahb_hrdata(ahb_hrdata[g]),
            .ahb_hresp(ahb_hresp[g]), .apb_paddr, .apb_psel, .apb_penable, .apb_pwrite, .apb_pwdata,
            .apb_pready(apb_pready[g]), .apb_prdata(apb_prdata[g]), .apb_pslverr(apb_pslverr[g])
        );
    end
    ihrp_host_model u_ihrp_host_model (
        .sys_clk, .lcl_ready(lcl_ready[0]), .lcl_rdata_valid(lcl_rdata_valid[0]), .lcl_rdata(lcl_rdata[0]),
        .ahb_hreadyout(ahb_hreadyout[2]), .ahb_hrdata(ahb_hrdata[2]), .apb_pready(apb_pready[1]),
        .apb_prdata(apb_prdata[1]), .lcl_req, .lcl_wr_rd_n, .lcl_offset, .lcl_wdata, .ahb_hsel, .ahb_haddr,
        .ahb_htrans, .ahb_hwrite, .ahb_hwdata, .apb_paddr, .apb_psel, .apb_penable, .apb_pwrite, .apb_pwdata
    );

    ////////////////////////////////////////////////////////////////
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    // Hang guard
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 3000) begin
            err_count++;
            $display("[FAIL] run length expected below 3000 seen %0d", cycles);
            give_verdict();
        end
        // bus outputs of unbuilt options stay idle
        if (!rst && {apb_pready[0], apb_pready[2], ahb_hreadyout[0], ahb_hreadyout[1]} !== 4'h3) begin
            stray <= 1'b1;
        end
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : give_verdict

    ////////////////////////////////////////////////////////////////
    task automatic t_local_rw();
        logic [7:0] offs [4] = '{8'h00, 8'hFF, 8'h7F, 8'h01};
        logic [7:0] vals [4] = '{8'h5A, 8'hA5, 8'h81, 8'h00};
        logic [7:0] b;
        chk("ready", 1, lcl_ready[0]);
        for (int i = 0; i < 3; i++) begin
            u_ihrp_host_model.lcl_xfer(1'b1, offs[i], vals[i], b);
        end
        for (int i = 0; i < 4; i++) begin
            u_ihrp_host_model.lcl_xfer(1'b0, offs[i], 8'h00, b);
            chk("local read", vals[i], b);
        end
        $display("test local_rw done");
    endtask : t_local_rw

    // Masked source, enabled source, other build, clear
    task automatic t_irq();
        logic [7:0] b;
        chk("irq idle", 0, host_irq[0]);
        u_ihrp_host_model.lcl_xfer(1'b1, IRQ_EN_OFF, 8'h05, b);
        irq_src <= 8'h02;
        repeat (3) @(posedge sys_clk);
        chk("irq masked", 0, host_irq[0]);
        irq_src <= 8'h04;
        repeat (3) @(posedge sys_clk);
        chk("irq raised", 1, host_irq[0]);
        chk("irq apb build", 0, host_irq[1]);
        u_ihrp_host_model.lcl_xfer(1'b0, IRQ_STAT_OFF, 8'h00, b);
        chk("irq sources", 8'h04, b);
        irq_src <= 8'h00;
        repeat (3) @(posedge sys_clk);
        chk("irq cleared", 0, host_irq[0]);
        $display("test irq done");
    endtask : t_irq

    // New rate, then a port reset that must spare it
    task automatic t_rate_reset();
        logic [7:0] b;
        for (int g = 0; g < 3; g++) chk("rate at reset", ODR_RST, sensor_odr[g]);
        xtime_odr       <= 8'hC3;
        xtime_odr_valid <= 1'b1;
        @(posedge sys_clk);
        xtime_odr_valid <= 1'b0;
        xtime_odr       <= 8'h3C;
        repeat (2) @(posedge sys_clk);
        for (int g = 0; g < 3; g++) chk("rate", 8'hC3, sensor_odr[g]);
        u_ihrp_host_model.lcl_xfer(1'b1, 8'h00, 8'h3C, b);
        u_ihrp_host_model.lcl_xfer(1'b1, IRQ_EN_OFF, 8'h01, b);
        irq_src <= 8'h01;
        repeat (3) @(posedge sys_clk);
        chk("irq before port reset", 1, host_irq[0]);
        lcl_rst_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        lcl_rst_n <= 1'b1;
        @(posedge sys_clk);
        chk("irq after port reset", 0, host_irq[0]);
        for (int g = 0; g < 3; g++) chk("rate kept", 8'hC3, sensor_odr[g]);
        u_ihrp_host_model.lcl_xfer(1'b0, 8'h00, 8'h00, b);
        chk("store cleared", MEM_RST, b);
        u_ihrp_host_model.lcl_xfer(1'b0, IRQ_EN_OFF, 8'h00, b);
        chk("enable cleared", IRQ_EN_RST, b);
        u_ihrp_host_model.lcl_xfer(1'b0, ODR_OFF, 8'h00, b);
        chk("rate register", 8'hC3, b);
        irq_src <= 8'h00;
        $display("test rate_reset done");
    endtask : t_rate_reset

    // High and low address bits set
    task automatic t_buses();
        logic [31:0] r;
        u_ihrp_host_model.apb_xfer(1'b1, 32'hABCD_E017, 32'h1234_5677, r);
        u_ihrp_host_model.apb_xfer(1'b0, 32'h0000_0014, 32'h0000_0000, r);
        chk("apb read", 32'h0000_0077, r);
        u_ihrp_host_model.apb_xfer(1'b0, 32'hFFFF_FC18, 32'h0000_0000, r);
        chk("apb unwritten", 32'h0000_0000, r);
        chk("apb error", 0, apb_pslverr[1]);
        u_ihrp_host_model.ahb_xfer(1'b1, 32'h5555_5C0B, 32'hDEAD_BE5A, r);
        u_ihrp_host_model.ahb_xfer(1'b0, 32'hFFFF_F808, 32'h0000_0000, r);
        chk("ahb read", 32'h0000_005A, r);
        chk("ahb response", 0, ahb_hresp[2]);
        chk("unbuilt idle", 0, stray);
        $display("test buses done");
    endtask : t_buses

    ////////////////////////////////////////////////////////////////
    initial begin
        rst             = 1'b1;
        lcl_rst_n       = 1'b0;
        irq_src         = 8'h00;
        xtime_odr_valid = 1'b0;
        xtime_odr       = 8'h00;
        repeat (3) @(posedge sys_clk);
        rst       <= 1'b0;
        lcl_rst_n <= 1'b1;
        repeat (2) @(posedge sys_clk);
        t_local_rw();
        t_irq();
        t_rate_reset();
        t_buses();
        give_verdict();
    end
endmodule : ihrp_top_bench
